// ### hw/bfsp_top.sv
/*
  boot flash section protection: gates page erase/write, program-load reads,
  interrupts and the reset vector by section, lock pairs and boot reset fuse.
  assumes one CPU core on the request ports, an AHB-Lite master with this
  as its only slave, and a programming port for fuses, locks and chip erase.
*/
`include "bfsp_cfg.svh"

module bfsp_top #(
  parameter int                  AW         = `BFSP_AW,
  parameter logic [AW-1:0]       NO_READ_WHILE_WRITE_SECTION_START = `BFSP_NO_READ_WHILE_WRITE_SECTION_START,
  parameter logic [AW-1:0]       BOOT_START = `BFSP_BOOT_START,
  parameter logic [15:0]         OP_CYCLES  = `BFSP_OP_CYCLES
) (
  // clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              RSTN,
  // ahb-lite slave
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic [31:0]            HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  // cpu core requests
  input  wire logic [AW-1:0]     CPU_PC,
  input  wire logic              STORE_REQ,
  input  wire logic              STORE_ERASE,
  input  wire logic [AW-1:0]     STORE_ADDR,
  input  wire logic              LOAD_REQ,
  input  wire logic [AW-1:0]     LOAD_ADDR,
  // cpu core answers
  output logic                   CPU_HALT,
  output logic                   FETCH_OK,
  output logic                   IRQ_EN,
  output logic                   STORE_ACCEPT,
  output logic                   LOAD_OK,
  output logic                   LOAD_DENY,
  output logic [AW-1:0]          RESET_VECTOR,
  // flash array control
  output logic                   FLASH_START,
  output logic                   FLASH_ERASE,
  output logic [AW-1:0]          FLASH_ADDR,
  output logic                   RWW_BUSY,
  // programming port
  input  wire logic              PROG_LOCK_WE,
  input  wire logic [5:0]        PROG_LOCK_VAL,
  input  wire logic              PROG_FUSE_WE,
  input  wire logic              PROG_FUSE_VAL,
  input  wire logic              PROG_CHIP_ERASE
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  bfsp_pkg::bfsp_state_t         state_r;
  bfsp_pkg::bfsp_state_t         state_nxt;
  logic [15:0]                   op_cnt_r;
  logic [`BFSP_LOCK_W-1:0]       lock_r;
  logic [`BFSP_LOCK_W-1:0]       lock_nxt;
  logic                          fuse_r;
  logic                          vec_boot_r;
  logic                          rww_busy_r;
  logic                          wr_pend_r;
  logic [7:0]                    ofs_r;
  logic [31:0]                   rd_mux;
  logic                          addr_ph;
  logic                          sw_wr_ctrl;
  logic                          sw_wr_lock;
  logic                          rww_clr;
  logic                          pc_boot;
  logic                          pc_rww;
  logic                          tgt_boot;
  logic                          tgt_no_read_while_write_section;
  logic                          ld_boot;
  logic                          ld_rww;
  logic                          app_wr_block;
  logic                          app_rd_block;
  logic                          ldr_wr_block;
  logic                          ldr_rd_block;
  logic                          store_ok;
  logic                          accept;
  logic                          load_block;

  // ****************************************************************
  // section and lock decode
  // ****************************************************************
  assign pc_boot  = (CPU_PC >= BOOT_START);
  assign pc_rww   = (CPU_PC < NO_READ_WHILE_WRITE_SECTION_START);
  assign tgt_boot = (STORE_ADDR >= BOOT_START);
  assign tgt_no_read_while_write_section = (STORE_ADDR >= NO_READ_WHILE_WRITE_SECTION_START);
  assign ld_boot  = (LOAD_ADDR >= BOOT_START);
  assign ld_rww   = (LOAD_ADDR < NO_READ_WHILE_WRITE_SECTION_START);
  assign app_wr_block = ~lock_r[`BFSP_LOCK_APP_LOWER];
  assign app_rd_block = ~lock_r[`BFSP_LOCK_APP_UPPER];
  assign ldr_wr_block = ~lock_r[`BFSP_LOCK_LDR_LOWER];
  assign ldr_rd_block = ~lock_r[`BFSP_LOCK_LDR_UPPER];
  // general lock bits left out of the gate
  assign store_ok = tgt_boot ? ~ldr_wr_block : ~app_wr_block;
  // store only from boot loader code
  assign accept = STORE_REQ && pc_boot && store_ok && (state_r == bfsp_pkg::BFSP_IDLE);
  assign load_block = (pc_boot && !ld_boot && app_rd_block)
                   || (!pc_boot && ld_boot && ldr_rd_block)
                   || (rww_busy_r && ld_rww);

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  assign addr_ph    = HSEL && HREADY && HTRANS[1];
  assign sw_wr_ctrl = wr_pend_r && (ofs_r == `BFSP_CTRL_OFS);
  assign sw_wr_lock = wr_pend_r && (ofs_r == `BFSP_LOCK_OFS);
  assign rww_clr    = sw_wr_ctrl && HWDATA[`BFSP_CTRL_RWW_CLR];

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      wr_pend_r <= 1'b0;
      ofs_r     <= 8'h00;
    end
    else if (addr_ph)
    begin
      wr_pend_r <= HWRITE;
      ofs_r     <= HADDR[7:0];
    end
    else
    begin
      wr_pend_r <= 1'b0;
    end
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (HADDR[7:0])
      `BFSP_CTRL_OFS: rd_mux[`BFSP_CTRL_VEC_BOOT] = vec_boot_r;
      `BFSP_STAT_OFS:
      begin
        rd_mux[`BFSP_STAT_RWW_BUSY]  = rww_busy_r;
        rd_mux[`BFSP_STAT_HALT]      = CPU_HALT;
        rd_mux[`BFSP_STAT_OP_BUSY]   = (state_r != bfsp_pkg::BFSP_IDLE);
        rd_mux[`BFSP_STAT_BOOT_FUSE] = fuse_r;
      end
      `BFSP_LOCK_OFS: rd_mux[`BFSP_LOCK_W-1:0] = lock_r;
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
    else
    begin
      HRDATA    <= (addr_ph && !HWRITE) ? rd_mux : 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      vec_boot_r <= `BFSP_CTRL_RST;
    else if (sw_wr_ctrl)
      vec_boot_r <= HWDATA[`BFSP_CTRL_VEC_BOOT];
  end

  // ****************************************************************
  // lock bits
  // ****************************************************************
  always_comb
  begin
    lock_nxt = lock_r;
    // program only, software or programming port
    // each pair keeps its own bits
    if (sw_wr_lock)
      lock_nxt = lock_nxt & HWDATA[`BFSP_LOCK_W-1:0];
    if (PROG_LOCK_WE)
      lock_nxt = lock_nxt & PROG_LOCK_VAL;
    // only chip erase or reset returns to unprogrammed
    if (PROG_CHIP_ERASE)
      lock_nxt = `BFSP_LOCK_RST;
  end

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      lock_r <= `BFSP_LOCK_RST;
    else
      lock_r <= lock_nxt;
  end

  // ****************************************************************
  // boot reset fuse and reset vector
  // ****************************************************************
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      fuse_r <= `BFSP_FUSE_RST;
    // fuse written by programming port only
    else if (PROG_FUSE_WE)
      fuse_r <= PROG_FUSE_VAL;
  end

  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      RESET_VECTOR <= `BFSP_APP_RESET;
    else
      RESET_VECTOR <= fuse_r ? AW'(`BFSP_APP_RESET) : BOOT_START;
  end

  // ****************************************************************
  // page operation sequencer
  // ****************************************************************
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      bfsp_pkg::BFSP_IDLE:
        if (accept)
          state_nxt = tgt_no_read_while_write_section ? bfsp_pkg::BFSP_RUN_NO_READ_WHILE_WRITE_SECTION : bfsp_pkg::BFSP_RUN_RWW;
      bfsp_pkg::BFSP_RUN_RWW,
      bfsp_pkg::BFSP_RUN_NO_READ_WHILE_WRITE_SECTION:
        if (op_cnt_r == 16'h0000)
          state_nxt = bfsp_pkg::BFSP_IDLE;
      default:
        state_nxt = bfsp_pkg::BFSP_IDLE;
    endcase
  end
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      state_r <= bfsp_pkg::BFSP_IDLE;
    else
      state_r <= state_nxt;
  end
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      op_cnt_r <= 16'h0000;
    else if (accept)
      op_cnt_r <= OP_CYCLES - 16'h0001;
    else if (op_cnt_r != 16'h0000)
      op_cnt_r <= op_cnt_r - 16'h0001;
  end
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      FLASH_START  <= 1'b0;
      FLASH_ERASE  <= 1'b0;
      FLASH_ADDR   <= '0;
      STORE_ACCEPT <= 1'b0;
    end
    else
    begin
      FLASH_START  <= accept;
      STORE_ACCEPT <= accept;
      if (accept)
      begin
        FLASH_ERASE <= STORE_ERASE;
        FLASH_ADDR  <= STORE_ADDR;
      end
    end
  end
  // halted for the whole no-read-while-write operation
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      CPU_HALT <= 1'b0;
    else
      CPU_HALT <= (state_nxt == bfsp_pkg::BFSP_RUN_NO_READ_WHILE_WRITE_SECTION);
  end
  // busy set by hardware, set wins over software clear
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      rww_busy_r <= 1'b0;
    else if (accept && !tgt_no_read_while_write_section)
      rww_busy_r <= 1'b1;
    else if (rww_clr && (state_r == bfsp_pkg::BFSP_IDLE))
      rww_busy_r <= 1'b0;
  end

  // ****************************************************************
  // fetch, load and interrupt gating
  // ****************************************************************
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      FETCH_OK  <= 1'b1;
      LOAD_OK   <= 1'b0;
      LOAD_DENY <= 1'b0;
      IRQ_EN    <= 1'b1;
      RWW_BUSY  <= 1'b0;
    end
    else
    begin
      RWW_BUSY  <= rww_busy_r;
      // fetch only outside the busy read-while-write section
      FETCH_OK  <= !(rww_busy_r && pc_rww) && (state_r != bfsp_pkg::BFSP_RUN_NO_READ_WHILE_WRITE_SECTION);
      LOAD_OK   <= LOAD_REQ && !load_block;
      // denied load answered on the next clock, no stall
      LOAD_DENY <= LOAD_REQ && load_block;
      // interrupts off in the guarded section
      IRQ_EN    <= !((vec_boot_r && app_rd_block && !pc_boot)
                  || (!vec_boot_r && ldr_rd_block && pc_boot));
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  a_no_read_while_write_section_halt_run: assert property (
    (accept && tgt_no_read_while_write_section) |=> CPU_HALT [*2])
    else $error("cpu not halted during no_read_while_write_section operation");
  a_rww_no_halt: assert property (
    (accept && !tgt_no_read_while_write_section) |=> (!CPU_HALT && rww_busy_r) ##1 RWW_BUSY)
    else $error("rww operation halted cpu or left busy low");
  a_rww_fetch_block: assert property (
    (rww_busy_r && pc_rww) |=> !FETCH_OK)
    else $error("fetch allowed from busy rww section");
  a_app_store_drop: assert property (
    (STORE_REQ && !pc_boot) |=> !FLASH_START && !STORE_ACCEPT)
    else $error("store from application section started programming");
  a_app_write_lock: assert property (
    (STORE_REQ && pc_boot && !tgt_boot && app_wr_block && state_r == bfsp_pkg::BFSP_IDLE)
      |=> !FLASH_START && !CPU_HALT)
    else $error("locked application section was programmed");
  a_ldr_write_lock: assert property (
    (STORE_REQ && tgt_boot && ldr_wr_block) |=> !FLASH_START)
    else $error("locked loader section was programmed");
  a_app_read_lock: assert property (
    (LOAD_REQ && pc_boot && !ld_boot && app_rd_block) |=> LOAD_DENY && !LOAD_OK)
    else $error("boot load of locked application section allowed");
  a_ldr_read_lock: assert property (
    (LOAD_REQ && !pc_boot && ld_boot && ldr_rd_block) |=> LOAD_DENY && !LOAD_OK)
    else $error("application load of locked loader section allowed");
  a_irq_mask: assert property (
    (vec_boot_r && app_rd_block && !pc_boot) |=> !IRQ_EN)
    else $error("interrupts left on in guarded application code");
  a_lock_no_clear: assert property (
    !PROG_CHIP_ERASE |=> ((lock_r & ~$past(lock_r)) == 6'h00))
    else $error("lock bit unprogrammed without chip erase");
  a_fuse_cpu_safe: assert property (
    !PROG_FUSE_WE |=> $stable(fuse_r))
    else $error("fuse changed without programming port");
  a_reset_vector: assert property (
    !fuse_r |=> (RESET_VECTOR == BOOT_START))
    else $error("programmed fuse gave wrong reset vector");
  c_rww_op:  cover property (accept && !tgt_no_read_while_write_section ##1 LOAD_REQ && ld_rww);
  c_no_read_while_write_section_op: cover property (accept && tgt_no_read_while_write_section ##1 CPU_HALT);
  c_deny:    cover property (LOAD_REQ && load_block ##1 LOAD_DENY);
  c_lock_wr: cover property (sw_wr_lock && (lock_nxt != lock_r));
endmodule

// ### hw/bfsp_cfg.svh
/*
  constants for the boot flash section protection block: register offsets,
  field positions, reset values and default section limits.
  assumes it is included by bare name from the top module and the test bench.
*/
`ifndef BFSP_CFG_SVH
`define BFSP_CFG_SVH

// ****************************************************************
// register offsets (byte address, low eight bits)
// ****************************************************************
`define BFSP_CTRL_OFS        8'h00
`define BFSP_STAT_OFS        8'h04
`define BFSP_LOCK_OFS        8'h08

// ****************************************************************
// field positions
// ****************************************************************
`define BFSP_CTRL_VEC_BOOT   0
`define BFSP_CTRL_RWW_CLR    1
`define BFSP_STAT_RWW_BUSY   0
`define BFSP_STAT_HALT       1
`define BFSP_STAT_OP_BUSY    2
`define BFSP_STAT_BOOT_FUSE  3
`define BFSP_LOCK_GEN_LO     0
`define BFSP_LOCK_GEN_HI     1
`define BFSP_LOCK_APP_LOWER  2
`define BFSP_LOCK_APP_UPPER  3
`define BFSP_LOCK_LDR_LOWER  4
`define BFSP_LOCK_LDR_UPPER  5

// ****************************************************************
// reset values and defaults
// ****************************************************************
`define BFSP_LOCK_W          6
`define BFSP_LOCK_RST        6'h3f
`define BFSP_FUSE_RST        1'h1
`define BFSP_CTRL_RST        1'h0
`define BFSP_AW              13
`define BFSP_NO_READ_WHILE_WRITE_SECTION_START      13'h1c00
`define BFSP_BOOT_START      13'h1e00
`define BFSP_APP_RESET       13'h0000
`define BFSP_OP_CYCLES       16'h0040

`endif

// ### hw/bfsp_pkg.sv
/*
  types of the boot flash section protection block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package bfsp_pkg;

  // ****************************************************************
  // page operation state
  // ****************************************************************
  typedef enum logic [1:0] {
    BFSP_IDLE,
    BFSP_RUN_RWW,
    BFSP_RUN_NO_READ_WHILE_WRITE_SECTION
  } bfsp_state_t;

endpackage

// ### tb/bfsp_cpu_model.sv
/*
  cpu core model: drives program counter, program-store and program-load.
  assumes the bench clock and the halt answer of the block.
*/
module bfsp_cpu_model #(
  parameter int AW = 13
) (
  // clock and halt
  input  wire logic          clk,
  input  wire logic          halt,
  // requests
  output logic [AW-1:0]      pc,
  output logic               st_req,
  output logic               st_erase,
  output logic [AW-1:0]      st_addr,
  output logic               ld_req,
  output logic [AW-1:0]      ld_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    pc = '0;
    st_req = 1'b0;
    st_erase = 1'b0;
    st_addr = '0;
    ld_req = 1'b0;
    ld_addr = '0;
  end

  // a halted core issues no store or load
  task automatic run();
    @(posedge clk);
    while (halt === 1'b1)
      @(posedge clk);
  endtask

  task automatic set_pc(input logic [AW-1:0] p);
    @(posedge clk);
    pc <= p;
  endtask

  // released qualifiers show the inverse
  task automatic store(input logic [AW-1:0] a, input logic er);
    run();
    st_req <= 1'b1;
    st_erase <= er;
    st_addr <= a;
    @(posedge clk);
    st_req <= 1'b0;
    st_erase <= ~er;
    st_addr <= ~a;
  endtask

  task automatic load(input logic [AW-1:0] a);
    run();
    ld_req <= 1'b1;
    ld_addr <= a;
    @(posedge clk);
    ld_req <= 1'b0;
    ld_addr <= ~a;
  endtask
endmodule

// ### tb/bfsp_test.sv
/*
  self-checking bench of the boot flash section protection block.
  assumes the hw/ design files and the cpu model of tb/.
*/
`include "bfsp_cfg.svh"
`define CHK(g, e) \
  n_checks++; \
  if ((g) !== (e)) \
  begin \
    miscompares++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
  end

module boot_flash_section_protection_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] OPC  = 16'h0004;
  localparam logic [12:0] BOOT = `BFSP_BOOT_START;
  localparam logic [12:0] NO_READ_WHILE_WRITE_SECTION = `BFSP_NO_READ_WHILE_WRITE_SECTION_START;
  localparam logic [12:0] APP  = 13'h0200;
  // ****************
  // signals
  // ****************
  logic        REF_CLK = 1'b0;
  logic        RSTN = 1'b0;
  logic        HSEL = 1'b0;
  logic [31:0] HADDR = '0;
  logic [1:0]  HTRANS = '0;
  logic        HWRITE = 1'b0;
  logic [2:0]  HSIZE = 3'h2;
  logic [31:0] HWDATA = '0;
  wire logic   HREADY;
  logic [31:0] HRDATA;
  logic        HREADYOUT, HRESP, CPU_HALT, FETCH_OK, IRQ_EN;
  logic        STORE_ACCEPT, LOAD_OK, LOAD_DENY, FLASH_START, FLASH_ERASE, RWW_BUSY;
  logic [12:0] CPU_PC, STORE_ADDR, LOAD_ADDR, RESET_VECTOR, FLASH_ADDR;
  logic        STORE_REQ, STORE_ERASE, LOAD_REQ;
  logic        PROG_LOCK_WE = 1'b0;
  logic [5:0]  PROG_LOCK_VAL = 6'h3f;
  logic        PROG_FUSE_WE = 1'b0;
  logic        PROG_FUSE_VAL = 1'b1;
  logic        PROG_CHIP_ERASE = 1'b0;
  int          miscompares = 0;
  int          n_checks = 0;

  assign HREADY = HREADYOUT;

  bfsp_top #(.OP_CYCLES(OPC)) bfsp_top_inst (
    .REF_CLK(REF_CLK), .RSTN(RSTN),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .CPU_PC(CPU_PC), .STORE_REQ(STORE_REQ), .STORE_ERASE(STORE_ERASE),
    .STORE_ADDR(STORE_ADDR), .LOAD_REQ(LOAD_REQ), .LOAD_ADDR(LOAD_ADDR),
    .CPU_HALT(CPU_HALT), .FETCH_OK(FETCH_OK), .IRQ_EN(IRQ_EN),
    .STORE_ACCEPT(STORE_ACCEPT), .LOAD_OK(LOAD_OK), .LOAD_DENY(LOAD_DENY),
    .RESET_VECTOR(RESET_VECTOR),
    .FLASH_START(FLASH_START), .FLASH_ERASE(FLASH_ERASE),
    .FLASH_ADDR(FLASH_ADDR), .RWW_BUSY(RWW_BUSY),
    .PROG_LOCK_WE(PROG_LOCK_WE), .PROG_LOCK_VAL(PROG_LOCK_VAL),
    .PROG_FUSE_WE(PROG_FUSE_WE), .PROG_FUSE_VAL(PROG_FUSE_VAL),
    .PROG_CHIP_ERASE(PROG_CHIP_ERASE)
  );

  bfsp_cpu_model bfsp_cpu_model_inst (
    .clk(REF_CLK), .halt(CPU_HALT), .pc(CPU_PC),
    .st_req(STORE_REQ), .st_erase(STORE_ERASE), .st_addr(STORE_ADDR),
    .ld_req(LOAD_REQ), .ld_addr(LOAD_ADDR)
  );

  initial
  begin
    forever
      #4 REF_CLK = ~REF_CLK;
  end

  // ****************
  // bus and port tasks
  // ****************
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge REF_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= {24'h0, a};
    do
      @(posedge REF_CLK);
    while (HREADY !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do
      @(posedge REF_CLK);
    while (HREADY !== 1'b1);
    rd = HRDATA;
  endtask

  // k: 1 lock write, 2 fuse write, 3 chip erase
  task automatic prog(input logic [1:0] k, input logic [5:0] v);
    @(posedge REF_CLK);
    PROG_LOCK_WE <= (k == 2'h1);
    PROG_FUSE_WE <= (k == 2'h2);
    PROG_CHIP_ERASE <= (k == 2'h3);
    PROG_LOCK_VAL <= v;
    PROG_FUSE_VAL <= v[0];
    @(posedge REF_CLK);
    PROG_LOCK_WE <= 1'b0;
    PROG_FUSE_WE <= 1'b0;
    PROG_CHIP_ERASE <= 1'b0;
  endtask

  task automatic lag();
    repeat (2)
      @(posedge REF_CLK);
    #1;
  endtask

  task automatic wait_idle();
    logic [31:0] rd;
    rd = 32'h4;
    for (int k = 0; k < 40 && rd[2] !== 1'b0; k++)
      ahb(1'b0, `BFSP_STAT_OFS, '0, rd);
    `CHK(rd[2], 1'b0)
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    logic [31:0] rd;
    `CHK({HREADYOUT, HRESP, CPU_HALT, FETCH_OK, IRQ_EN}, 5'b10011)
    `CHK(RESET_VECTOR, 13'h0000)
    ahb(1'b0, `BFSP_LOCK_OFS, '0, rd);
    `CHK(rd, 32'h3f)
    ahb(1'b0, `BFSP_STAT_OFS, '0, rd);
    `CHK(rd, 32'h8)
    ahb(1'b1, 8'h0c, 32'h0, rd);
    ahb(1'b0, 8'h0c, '0, rd);
    `CHK(rd, 32'h0)
  endtask

  task automatic t_rww();
    logic [31:0] rd;
    ahb(1'b1, `BFSP_LOCK_OFS, 32'h3c, rd);
    bfsp_cpu_model_inst.set_pc(APP);
    bfsp_cpu_model_inst.store(13'h0100, 1'b0);
    #1;
    `CHK({STORE_ACCEPT, CPU_HALT}, 2'b00)
    bfsp_cpu_model_inst.set_pc(BOOT);
    bfsp_cpu_model_inst.store(13'h0100, 1'b0);
    #1;
    `CHK({STORE_ACCEPT, FLASH_START, FLASH_ERASE, CPU_HALT}, 4'b1100)
    `CHK(FLASH_ADDR, 13'h0100)
    bfsp_cpu_model_inst.load(13'h0100);
    #1;
    `CHK({LOAD_OK, LOAD_DENY}, 2'b01)
    bfsp_cpu_model_inst.load(NO_READ_WHILE_WRITE_SECTION);
    #1;
    `CHK({LOAD_OK, RWW_BUSY}, 2'b11)
    bfsp_cpu_model_inst.set_pc(13'h0100);
    lag();
    `CHK(FETCH_OK, 1'b0)
    bfsp_cpu_model_inst.set_pc(BOOT);
    wait_idle();
    ahb(1'b0, `BFSP_STAT_OFS, '0, rd);
    `CHK(rd[0], 1'b1)
    ahb(1'b1, `BFSP_CTRL_OFS, 32'h2, rd);
    ahb(1'b0, `BFSP_STAT_OFS, '0, rd);
    `CHK(rd[0], 1'b0)
    bfsp_cpu_model_inst.load(13'h0100);
    #1;
    `CHK(LOAD_OK, 1'b1)
  endtask

  task automatic t_no_read_while_write_section();
    logic [7:0] n;
    n = 8'h0;
    bfsp_cpu_model_inst.store(NO_READ_WHILE_WRITE_SECTION + 13'h10, 1'b1);
    #1;
    `CHK({STORE_ACCEPT, FLASH_ERASE, CPU_HALT, RWW_BUSY}, 4'b1110)
    while (CPU_HALT === 1'b1 && n < 8'h40)
    begin
      n++;
      @(posedge REF_CLK);
      #1;
    end
    `CHK(n, 8'(OPC))
    wait_idle();
  endtask

  // pair 0: application pair, pair 1: loader pair
  task automatic t_locks(input logic pair);
    logic [1:0]  modes [4] = '{2'b11, 2'b10, 2'b00, 2'b01};
    logic [31:0] rd;
    logic [31:0] lk;
    for (int i = 0; i < 4; i++)
    begin
      lk = pair ? {26'h0, modes[i], 4'hf} : {26'h0, 2'h3, modes[i], 2'h3};
      prog(2'h3, 6'h3f);
      ahb(1'b1, `BFSP_LOCK_OFS, lk, rd);
      ahb(1'b0, `BFSP_LOCK_OFS, '0, rd);
      `CHK(rd, lk)
      ahb(1'b1, `BFSP_CTRL_OFS, {31'h0, ~pair}, rd);
      bfsp_cpu_model_inst.set_pc(pair ? BOOT : APP);
      lag();
      `CHK(IRQ_EN, modes[i][1])
      bfsp_cpu_model_inst.set_pc(pair ? APP : BOOT);
      bfsp_cpu_model_inst.load(pair ? BOOT : APP);
      #1;
      `CHK({LOAD_OK, LOAD_DENY}, {modes[i][1], ~modes[i][1]})
      bfsp_cpu_model_inst.set_pc(BOOT);
      bfsp_cpu_model_inst.store(pair ? BOOT + 13'h10 : NO_READ_WHILE_WRITE_SECTION, 1'b0);
      #1;
      `CHK({STORE_ACCEPT, FLASH_START, CPU_HALT}, {3{modes[i][0]}})
      wait_idle();
    end
  endtask

  task automatic t_perm();
    logic [31:0] rd;
    prog(2'h3, 6'h3f);
    ahb(1'b1, `BFSP_LOCK_OFS, 32'h0, rd);
    ahb(1'b1, `BFSP_LOCK_OFS, 32'h3f, rd);
    prog(2'h1, 6'h3f);
    ahb(1'b0, `BFSP_LOCK_OFS, '0, rd);
    `CHK(rd, 32'h0)
    prog(2'h3, 6'h3f);
    prog(2'h1, 6'h2b);
    ahb(1'b0, `BFSP_LOCK_OFS, '0, rd);
    `CHK(rd, 32'h2b)
    ahb(1'b1, `BFSP_STAT_OFS, 32'h0, rd);
    ahb(1'b0, `BFSP_STAT_OFS, '0, rd);
    `CHK(rd[3], 1'b1)
    prog(2'h2, 6'h0);
    ahb(1'b0, `BFSP_STAT_OFS, '0, rd);
    `CHK(rd[3], 1'b0)
    `CHK(RESET_VECTOR, BOOT)
  endtask

  task automatic summarize();
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (12)
      @(posedge REF_CLK);
    RSTN <= 1'b1;
    @(posedge REF_CLK);
    #1;
    t_reset();
    t_rww();
    t_no_read_while_write_section();
    t_locks(1'b0);
    t_locks(1'b1);
    t_perm();
    summarize();
  end

  initial
  begin
    repeat (20000)
      @(posedge REF_CLK);
    miscompares++;
    summarize();
  end
endmodule
